/* File: dv/ssem_host_model.sv */
// Host controller issuing status commands
`timescale 1ns/1ps
module ssem_host_model
   import ssem_pkg::*;
(
   input  wire logic      mclk,
   output      ssem_cmd_t cmd,
   input  wire ssem_rsp_t rsp
);
   initial cmd = '0;
   task automatic xfer(input ssem_op_t op, input ssem_sel_t sel,
                       input logic [REG_W-1:0] d,
                       output logic [REG_W-1:0] q);
      @(negedge mclk);
      cmd <= '{1'b1, op, sel, d};
      @(negedge mclk);
      // Answer stands one cycle only, so it is taken here
      q = rsp.valid ? rsp.data : 16'hXXXX;
      // Released data inverted so a stale word is never read as valid
      cmd <= '{1'b0, op, sel, ~d};
   endtask
endmodule

/* File: dv/ssem_monitor.sv */
// Port checks for the status event and mask block
`timescale 1ns/1ps
module ssem_monitor
   import ssem_pkg::*;
(
   input wire logic             mclk,
   input wire logic             reset,
   input wire ssem_cmd_t        cmd,
   input wire logic [REG_W-1:0] oper_events,
   input wire logic [REG_W-1:0] trig_events,
   input wire logic [REG_W-1:0] arm_events,
   input wire logic             first_arm_layer_flag,
   input wire logic             second_arm_layer_flag,
   input wire logic             too_many_closed,
   input wire ssem_rsp_t        rsp,
   input wire ssem_summary_t    summary,
   input wire logic [REG_W-1:0] arm_layer_sequence_events,
   input wire logic [REG_W-1:0] questionable_events
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic rd;
   logic clrq;
   assign rd = cmd.valid && cmd.op == OP_READ;
   assign clrq = cmd.valid && (cmd.op == OP_CLEAR ||
                 (rd && cmd.sel == SEL_QUES_EVENTS));
   a_read_answer: assert property (rd |=> rsp.valid)
      else $error("read gave no answer");
   a_no_spurious: assert property (!rd |=> !rsp.valid)
      else $error("answer without a read");
   a_oper_blocked: assert property (summary.oper |->
      |($past(oper_events) & OPER_USED)) else $error("oper summary");
   a_arm_blocked: assert property (summary.arm |->
      |($past(arm_events) & ARM_USED)) else $error("arm summary");
   a_seq_summary: assert property (summary.seq |->
      |($past(arm_layer_sequence_events) & SEQ_USED))
      else $error("seq summary without event");
   a_unused_zero: assert property (((arm_layer_sequence_events & ~SEQ_USED)
      | (questionable_events & ~QUES_USED)) == '0)
      else $error("unused event bit set");
   a_layer_cause: assert property ($rose(arm_layer_sequence_events[1]) |->
      $past(first_arm_layer_flag) != $past(first_arm_layer_flag, 2))
      else $error("layer event without transition");
   a_event_sticky: assert property ($fell(questionable_events[9]) |->
      $past(clrq)) else $error("event lost without clear");
   a_reset_quiet: assert property ($fell(reset) |->
      summary == '0 && !rsp.valid) else $error("not quiet after reset");
   c_read: cover property (rd ##1 rsp.valid);
   c_seq_sum: cover property ($rose(summary.seq));
   c_ques_sum: cover property ($rose(summary.ques));
endmodule
bind ssem_status_block ssem_monitor mon (.mclk(mclk), .reset(reset),
   .cmd(cmd), .oper_events(oper_events), .trig_events(trig_events),
   .arm_events(arm_events), .first_arm_layer_flag(first_arm_layer_flag),
   .second_arm_layer_flag(second_arm_layer_flag), .rsp(rsp),
   .too_many_closed(too_many_closed), .summary(summary),
   .arm_layer_sequence_events(arm_layer_sequence_events),
   .questionable_events(questionable_events));

/* File: dv/tb.sv */
// Self-checking bench for the status event and mask block
`timescale 1ns/1ps
module tb;
   import ssem_pkg::*;
   typedef struct packed
   {
      ssem_sel_t        sel;
      logic [REG_W-1:0] w;
      logic [REG_W-1:0] exp;
      logic [REG_W-1:0] ev;
      logic [2:0]       s;
   } ssem_row_t;
   localparam ssem_row_t ROWS [9] = '{
      '{SEL_OPER_MASK, 16'h0402, 16'h0402, 16'h0020, 3'h0},
      '{SEL_OPER_MASK, 16'h0060, 16'h0060, 16'h0020, 3'h4},
      '{SEL_TRIG_MASK, 16'hFFFF, 16'h0002, 16'h0002, 3'h2},
      '{SEL_ARM_MASK,  16'hFFFF, 16'h0002, 16'h0002, 3'h3},
      '{SEL_ARM_MASK,  16'h0000, 16'h0000, 16'h0002, 3'h2},
      '{SEL_OPER_MASK, 16'hFFFF, 16'h0462, 16'h0400, 3'h4},
      '{SEL_SEQ_MASK,  16'hFFFF, 16'h0006, 16'h0000, 3'h0},
      '{SEL_QUES_MASK, 16'hFFFF, 16'h0200, 16'h0000, 3'h0},
      '{SEL_SEQ_MASK,  16'h0004, 16'h0004, 16'h0000, 3'h0}};
   logic             mclk;
   logic             reset;
   logic             fl1;
   logic             fl2;
   logic             tmc;
   logic [REG_W-1:0] ev;
   logic [REG_W-1:0] q;
   logic [REG_W-1:0] seq_ev;
   logic [REG_W-1:0] ques_ev;
   ssem_cmd_t        cmd;
   ssem_rsp_t        rsp;
   ssem_summary_t    sum;
   int               n_mismatch = 0;
   int               num_checks = 0;

   ssem_host_model host (.mclk(mclk), .cmd(cmd), .rsp(rsp));
   ssem_status_block uut (.mclk(mclk), .reset(reset), .cmd(cmd),
      .oper_events(ev), .trig_events(ev), .arm_events(ev),
      .first_arm_layer_flag(fl1), .second_arm_layer_flag(fl2),
      .too_many_closed(tmc), .rsp(rsp), .summary(sum),
      .arm_layer_sequence_events(seq_ev), .questionable_events(ques_ev));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                      input string m);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Event then summary settle within three edges
   task automatic w3;
      repeat (3) @(negedge mclk);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (4000) @(posedge mclk);
      n_mismatch++;
      finish_test;
   end

   initial
   begin
      reset = 1'b1;
      ev = '0;
      fl1 = 1'b0;
      fl2 = 1'b0;
      tmc = 1'b0;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      for (int s = 0; s < 5; s++)
      begin
         host.xfer(OP_READ, ssem_sel_t'(s), 16'h0000, q);
         cmp(q, 16'h0000, "mask after reset");
      end
      host.xfer(OP_READ, SEL_QUES_RISING, 16'h0000, q);
      cmp(q, 16'h0200, "rising filter after reset");
      $display("test reset done");
      foreach (ROWS[i])
      begin
         ev = ROWS[i].ev;
         host.xfer(OP_WRITE, ROWS[i].sel, ROWS[i].w, q);
         host.xfer(OP_READ, ROWS[i].sel, 16'h0000, q);
         cmp(q, ROWS[i].exp, "mask readback");
         cmp({13'h0, sum[4:2]}, {13'h0, ROWS[i].s}, "summary");
      end
      $display("test masks done");
      fl1 = 1'b1;
      w3;
      cmp(seq_ev, 16'h0002, "layer one event");
      cmp({15'h0, sum.seq}, 16'h0000, "masked seq summary");
      fl2 = 1'b1;
      w3;
      cmp(seq_ev, 16'h0006, "layer two event");
      cmp({15'h0, sum.seq}, 16'h0001, "seq summary");
      host.xfer(OP_READ, SEL_SEQ_EVENTS, 16'h0000, q);
      cmp(q, 16'h0006, "seq event read");
      cmp(seq_ev, 16'h0000, "seq cleared by read");
      host.xfer(OP_WRITE, SEL_SEQ_RISING, 16'h0000, q);
      host.xfer(OP_WRITE, SEL_SEQ_FALLING, 16'h0002, q);
      fl1 = 1'b0;
      fl2 = 1'b0;
      w3;
      cmp(seq_ev, 16'h0002, "falling filter");
      $display("test sequence done");
      tmc = 1'b1;
      w3;
      cmp(ques_ev, 16'h0200, "too many closed");
      cmp({15'h0, sum.ques}, 16'h0001, "ques summary");
      host.xfer(OP_CLEAR, SEL_OPER_MASK, 16'h0000, q);
      cmp(ques_ev, 16'h0000, "clear status");
      host.xfer(OP_READ, SEL_QUES_MASK, 16'h0000, q);
      cmp(q, 16'h0200, "mask kept by clear");
      host.xfer(OP_PRESET, SEL_OPER_MASK, 16'h0000, q);
      host.xfer(OP_READ, SEL_QUES_MASK, 16'h0000, q);
      cmp(q, 16'h0000, "mask after preset");
      host.xfer(OP_READ, SEL_SEQ_RISING, 16'h0000, q);
      cmp(q, 16'h0006, "rising after preset");
      host.xfer(OP_WRITE, SEL_QUES_EVENTS, 16'hFFFF, q);
      cmp(ques_ev, 16'h0000, "event write ignored");
      host.xfer(OP_READ, ssem_sel_t'(4'hB), 16'h0000, q);
      cmp(q, 16'h0000, "unmapped read");
      $display("test status done");
      host.xfer(OP_WRITE, SEL_QUES_RISING, 16'h0000, q);
      host.xfer(OP_WRITE, SEL_QUES_FALLING, 16'hFFFF, q);
      host.xfer(OP_READ, SEL_QUES_FALLING, 16'h0000, q);
      cmp(q, 16'h0200, "falling filter used bits");
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      host.xfer(OP_READ, SEL_QUES_RISING, 16'h0000, q);
      cmp(q, 16'h0200, "rising after second reset");
      host.xfer(OP_READ, SEL_SEQ_FALLING, 16'h0000, q);
      cmp(q, 16'h0000, "falling after second reset");
      cmp(ques_ev, 16'h0200, "rise seen at release");
      $display("test second reset done");
      finish_test;
   end
endmodule

/* File: hdl/ssem_event_latch.sv */
// Transition filter and sticky event register for one register set
`timescale 1ns/1ps
module ssem_event_latch
   import ssem_pkg::*;
#(
   parameter logic [REG_W-1:0] USED = 16'h0000
)
(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [REG_W-1:0] cond,
   input  wire logic [REG_W-1:0] rising_en,
   input  wire logic [REG_W-1:0] falling_en,
   input  wire logic             clr,
   output      logic [REG_W-1:0] events
);

   typedef struct packed
   {
      logic [REG_W-1:0] prev_ff;
      logic [REG_W-1:0] evt_ff;
   } ssem_latch_st_t;

   ssem_latch_st_t st_ff;
   ssem_latch_st_t nxt_st;
   logic [REG_W-1:0] hit;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.prev_ff = cond & USED;
      hit = ((cond & ~st_ff.prev_ff & rising_en) |
             (~cond & st_ff.prev_ff & falling_en)) & USED;
      // Set wins over a same-cycle clear so no event is lost
      nxt_st.evt_ff = (clr ? EVENT_RST : st_ff.evt_ff) | hit;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign events = st_ff.evt_ff;

endmodule

/* File: hdl/ssem_pkg.sv */
// Shared constants and carrier types for the status event and mask block
package ssem_pkg;

   localparam int unsigned REG_W = 16;

   // Bit positions of the live event flags
   localparam int unsigned BIT_SETTLING      = 1;
   localparam int unsigned BIT_WAIT_TRIG     = 5;
   localparam int unsigned BIT_WAIT_ARM      = 6;
   localparam int unsigned BIT_IDLE          = 10;
   localparam int unsigned BIT_FIRST_SEQ     = 1;
   localparam int unsigned BIT_FIRST_LAYER   = 1;
   localparam int unsigned BIT_SECOND_LAYER  = 2;
   localparam int unsigned BIT_TOO_MANY_CHAN = 9;

   // Implemented bits of each register; all others read zero
   localparam logic [REG_W-1:0] OPER_USED = 16'h0462;
   localparam logic [REG_W-1:0] TRIG_USED = 16'h0002;
   localparam logic [REG_W-1:0] ARM_USED  = 16'h0002;
   localparam logic [REG_W-1:0] SEQ_USED  = 16'h0006;
   localparam logic [REG_W-1:0] QUES_USED = 16'h0200;

   // Values after power-up and status preset; the event value is loaded at power-up and on clear
   localparam logic [REG_W-1:0] MASK_RST    = 16'h0000;
   localparam logic [REG_W-1:0] RISING_RST  = 16'hFFFF;
   localparam logic [REG_W-1:0] FALLING_RST = 16'h0000;
   localparam logic [REG_W-1:0] EVENT_RST   = 16'h0000;

   // Register selects of the status command port
   typedef enum logic [3:0]
   {
      SEL_OPER_MASK    = 4'h0,
      SEL_TRIG_MASK    = 4'h1,
      SEL_ARM_MASK     = 4'h2,
      SEL_SEQ_MASK     = 4'h3,
      SEL_QUES_MASK    = 4'h4,
      SEL_SEQ_EVENTS   = 4'h5,
      SEL_QUES_EVENTS  = 4'h6,
      SEL_SEQ_RISING   = 4'h7,
      SEL_SEQ_FALLING  = 4'h8,
      SEL_QUES_RISING  = 4'h9,
      SEL_QUES_FALLING = 4'hA
   } ssem_sel_t;

   typedef enum logic [1:0]
   {
      OP_READ   = 2'h0,
      OP_WRITE  = 2'h1,
      OP_CLEAR  = 2'h2,
      OP_PRESET = 2'h3
   } ssem_op_t;

   typedef struct packed
   {
      logic             valid;
      ssem_op_t         op;
      ssem_sel_t        sel;
      logic [REG_W-1:0] data;
   } ssem_cmd_t;

   typedef struct packed
   {
      logic             valid;
      logic [REG_W-1:0] data;
   } ssem_rsp_t;

   typedef struct packed
   {
      logic oper;
      logic trig;
      logic arm;
      logic seq;
      logic ques;
   } ssem_summary_t;

   // Any unmasked event set
   function automatic logic masked_any(input logic [REG_W-1:0] evt,
                                       input logic [REG_W-1:0] en);
      masked_any = |(evt & en);
   endfunction

endpackage

/* File: hdl/ssem_status_block.sv */
// Status event registers, transition filters and event mask registers
//
// Behaviour
// - Sequence event bit 1 latches first arm layer entry or exit.
// - Sequence event bit 2 latches second arm layer entry or exit.
// - Questionable bit 9 latches too-many-channels-closed set or clear.
// - Five independent 16-bit mask registers: operation, trigger, arm, etc.
// - A cleared mask bit keeps its event from the summary bit.
// - A set mask bit passes its set event to the summary bit.
// - Host writes weight sum; each mask bit loads from its binary form.
// - Operation mask bits at 10, 6, 5 and 1.
// - Trigger mask holds one bit at position 1.
// - Arm mask holds one first-sequence bit; 1 enables, 0 masks.
// - Sequence mask bits at 2 and 1 for the arm layers.
// - Questionable mask holds only bit 9; others unused.
// - Mask query returns exactly the mask bits currently set.
// - Rising filter latches 0 to 1; falling filter latches 1 to 0.
// - Rising filter registers come up with every implemented bit set.
`timescale 1ns/1ps
module ssem_status_block
   import ssem_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire ssem_cmd_t        cmd,
   input  wire logic [REG_W-1:0] oper_events,
   input  wire logic [REG_W-1:0] trig_events,
   input  wire logic [REG_W-1:0] arm_events,
   input  wire logic             first_arm_layer_flag,
   input  wire logic             second_arm_layer_flag,
   input  wire logic             too_many_closed,
   output      ssem_rsp_t        rsp,
   output      ssem_summary_t    summary,
   output      logic [REG_W-1:0] arm_layer_sequence_events,
   output      logic [REG_W-1:0] questionable_events
);

   typedef struct packed
   {
      logic [REG_W-1:0] oper_mask_ff;
      logic [REG_W-1:0] trig_mask_ff;
      logic [REG_W-1:0] arm_mask_ff;
      logic [REG_W-1:0] seq_mask_ff;
      logic [REG_W-1:0] ques_mask_ff;
      logic [REG_W-1:0] seq_rising_ff;
      logic [REG_W-1:0] seq_falling_ff;
      logic [REG_W-1:0] ques_rising_ff;
      logic [REG_W-1:0] ques_falling_ff;
      ssem_rsp_t        rsp_ff;
   } ssem_main_st_t;

   // One write strobe per writable register
   typedef struct packed
   {
      logic oper;
      logic trig;
      logic arm;
      logic seq;
      logic ques;
      logic seq_rise;
      logic seq_fall;
      logic ques_rise;
      logic ques_fall;
   } ssem_wr_sel_t;

   ssem_main_st_t    st_ff;
   ssem_main_st_t    nxt_st;
   ssem_wr_sel_t     wr_sel;
   logic [REG_W-1:0] rd_word;
   logic [REG_W-1:0] seq_cond;
   logic [REG_W-1:0] ques_cond;
   logic [REG_W-1:0] seq_evt;
   logic [REG_W-1:0] ques_evt;
   logic             seq_clr;
   logic             ques_clr;
   logic             rd;
   logic             wr;
   logic             clr_all;
   logic             preset;

   // Command of one kind present at this edge
   function automatic logic cmd_is(input ssem_cmd_t c,
                                   input ssem_op_t  op);
      cmd_is = c.valid && (c.op == op);
   endfunction

   // Read of one register present at this edge
   function automatic logic read_of(input ssem_cmd_t c,
                                    input ssem_sel_t s);
      read_of = cmd_is(c, OP_READ) && (c.sel == s);
   endfunction

   always_comb
   begin
      seq_cond = '0;
      seq_cond[BIT_FIRST_LAYER]  = first_arm_layer_flag;
      seq_cond[BIT_SECOND_LAYER] = second_arm_layer_flag;
      ques_cond = '0;
      ques_cond[BIT_TOO_MANY_CHAN] = too_many_closed;
   end

   assign rd      = cmd_is(cmd, OP_READ);
   assign wr      = cmd_is(cmd, OP_WRITE);
   assign clr_all = cmd_is(cmd, OP_CLEAR);
   assign preset  = cmd_is(cmd, OP_PRESET);

   // Event registers clear when read, and on clear status
   assign seq_clr  = clr_all || read_of(cmd, SEL_SEQ_EVENTS);
   assign ques_clr = clr_all || read_of(cmd, SEL_QUES_EVENTS);

   // Event selects and undecoded codes raise no strobe
   // Such writes are dropped rather than reported to the host
   always_comb
   begin
      wr_sel = '0;
      if (wr)
      begin
         unique case (cmd.sel)
            SEL_OPER_MASK:    wr_sel.oper      = 1'b1;
            SEL_TRIG_MASK:    wr_sel.trig      = 1'b1;
            SEL_ARM_MASK:     wr_sel.arm       = 1'b1;
            SEL_SEQ_MASK:     wr_sel.seq       = 1'b1;
            SEL_QUES_MASK:    wr_sel.ques      = 1'b1;
            SEL_SEQ_RISING:   wr_sel.seq_rise  = 1'b1;
            SEL_SEQ_FALLING:  wr_sel.seq_fall  = 1'b1;
            SEL_QUES_RISING:  wr_sel.ques_rise = 1'b1;
            SEL_QUES_FALLING: wr_sel.ques_fall = 1'b1;
            default:          wr_sel           = '0;
         endcase
      end
   end

   // Undecoded select answers zero rather than stalling the host
   always_comb
   begin
      rd_word = '0;
      unique case (cmd.sel)
         SEL_OPER_MASK:    rd_word = st_ff.oper_mask_ff;
         SEL_TRIG_MASK:    rd_word = st_ff.trig_mask_ff;
         SEL_ARM_MASK:     rd_word = st_ff.arm_mask_ff;
         SEL_SEQ_MASK:     rd_word = st_ff.seq_mask_ff;
         SEL_QUES_MASK:    rd_word = st_ff.ques_mask_ff;
         SEL_SEQ_EVENTS:   rd_word = seq_evt;
         SEL_QUES_EVENTS:  rd_word = ques_evt;
         SEL_SEQ_RISING:   rd_word = st_ff.seq_rising_ff;
         SEL_SEQ_FALLING:  rd_word = st_ff.seq_falling_ff;
         SEL_QUES_RISING:  rd_word = st_ff.ques_rising_ff;
         SEL_QUES_FALLING: rd_word = st_ff.ques_falling_ff;
         default:          rd_word = '0;
      endcase
   end

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rsp_ff.valid = 1'b0;
      // One op per command, so the branches below never overlap
      // Parser has turned the decimal weight sum into binary
      if (wr_sel.oper)
      begin
         nxt_st.oper_mask_ff = cmd.data & OPER_USED;
      end
      if (wr_sel.trig)
      begin
         nxt_st.trig_mask_ff = cmd.data & TRIG_USED;
      end
      if (wr_sel.arm)
      begin
         nxt_st.arm_mask_ff = cmd.data & ARM_USED;
      end
      if (wr_sel.seq)
      begin
         nxt_st.seq_mask_ff = cmd.data & SEQ_USED;
      end
      if (wr_sel.ques)
      begin
         nxt_st.ques_mask_ff = cmd.data & QUES_USED;
      end
      if (wr_sel.seq_rise)
      begin
         nxt_st.seq_rising_ff = cmd.data & SEQ_USED;
      end
      if (wr_sel.seq_fall)
      begin
         nxt_st.seq_falling_ff = cmd.data & SEQ_USED;
      end
      if (wr_sel.ques_rise)
      begin
         nxt_st.ques_rising_ff = cmd.data & QUES_USED;
      end
      if (wr_sel.ques_fall)
      begin
         nxt_st.ques_falling_ff = cmd.data & QUES_USED;
      end
      if (rd)
      begin
         nxt_st.rsp_ff.valid = 1'b1;
         nxt_st.rsp_ff.data  = rd_word;
      end
      if (preset)
      begin
         nxt_st.oper_mask_ff    = MASK_RST;
         nxt_st.trig_mask_ff    = MASK_RST;
         nxt_st.arm_mask_ff     = MASK_RST;
         nxt_st.seq_mask_ff     = MASK_RST;
         nxt_st.ques_mask_ff    = MASK_RST;
         nxt_st.seq_rising_ff   = RISING_RST & SEQ_USED;
         nxt_st.ques_rising_ff  = RISING_RST & QUES_USED;
         nxt_st.seq_falling_ff  = FALLING_RST;
         nxt_st.ques_falling_ff = FALLING_RST;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st_ff.oper_mask_ff    <= MASK_RST;
         st_ff.trig_mask_ff    <= MASK_RST;
         st_ff.arm_mask_ff     <= MASK_RST;
         st_ff.seq_mask_ff     <= MASK_RST;
         st_ff.ques_mask_ff    <= MASK_RST;
         st_ff.seq_rising_ff   <= RISING_RST & SEQ_USED;
         st_ff.ques_rising_ff  <= RISING_RST & QUES_USED;
         st_ff.seq_falling_ff  <= FALLING_RST;
         st_ff.ques_falling_ff <= FALLING_RST;
         st_ff.rsp_ff          <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   ssem_event_latch #(
      .USED (SEQ_USED)
   ) u_seq_latch (
      .mclk       (mclk),
      .reset      (reset),
      .cond       (seq_cond),
      .rising_en  (st_ff.seq_rising_ff),
      .falling_en (st_ff.seq_falling_ff),
      .clr        (seq_clr),
      .events     (seq_evt)
   );

   ssem_event_latch #(
      .USED (QUES_USED)
   ) u_ques_latch (
      .mclk       (mclk),
      .reset      (reset),
      .cond       (ques_cond),
      .rising_en  (st_ff.ques_rising_ff),
      .falling_en (st_ff.ques_falling_ff),
      .clr        (ques_clr),
      .events     (ques_evt)
   );

   // Upstream event inputs are trusted to be sticky already
   ssem_summary u_sum_oper (
      .mclk    (mclk),
      .reset   (reset),
      .events  (oper_events),
      .mask    (st_ff.oper_mask_ff),
      .summary (summary.oper)
   );

   ssem_summary u_sum_trig (
      .mclk    (mclk),
      .reset   (reset),
      .events  (trig_events),
      .mask    (st_ff.trig_mask_ff),
      .summary (summary.trig)
   );

   ssem_summary u_sum_arm (
      .mclk    (mclk),
      .reset   (reset),
      .events  (arm_events),
      .mask    (st_ff.arm_mask_ff),
      .summary (summary.arm)
   );

   ssem_summary u_sum_seq (
      .mclk    (mclk),
      .reset   (reset),
      .events  (seq_evt),
      .mask    (st_ff.seq_mask_ff),
      .summary (summary.seq)
   );

   ssem_summary u_sum_ques (
      .mclk    (mclk),
      .reset   (reset),
      .events  (ques_evt),
      .mask    (st_ff.ques_mask_ff),
      .summary (summary.ques)
   );

   assign rsp                       = st_ff.rsp_ff;
   assign arm_layer_sequence_events = seq_evt;
   assign questionable_events       = ques_evt;

endmodule

/* File: hdl/ssem_summary.sv */
// Registered summary bit from one event register and its mask
`timescale 1ns/1ps
module ssem_summary
   import ssem_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [REG_W-1:0] events,
   input  wire logic [REG_W-1:0] mask,
   output      logic             summary
);

   typedef struct packed
   {
      logic sum_ff;
   } ssem_sum_st_t;

   ssem_sum_st_t st_ff;
   ssem_sum_st_t nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sum_ff = masked_any(events, mask);
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign summary = st_ff.sum_ff;

endmodule
